// file: hw/pipc_pkg.sv
// package: register map, field positions and timing for the phy interrupt/power control block
package pipc_pkg;
    // register indices (printed offsets), byte address is four times the index
    localparam logic [7:0]  IDX_SPECIAL_CONTROL = 8'h11;
    localparam logic [7:0]  IDX_INT_ONE         = 8'h12;
    localparam logic [7:0]  IDX_INT_TWO         = 8'h13;
    localparam logic [7:0]  IDX_FALSE_CARRIER   = 8'h14;
    localparam logic [7:0]  IDX_RX_ERROR        = 8'h15;
    localparam logic [7:0]  IDX_PHY_INPUTS      = 8'h16;
    localparam int          ADDR_LSB            = 2;
    // reset values
    localparam logic [15:0] RST_SPECIAL_CONTROL = 16'h0108;
    localparam logic [15:0] RST_INT_ONE         = 16'h0000;
    localparam logic [15:0] RST_INT_TWO         = 16'h0000;
    // special control field positions
    localparam int          SC_CLK_DIS   = 15;
    localparam int          SC_PS_EN     = 14;
    localparam int          SC_PS_HI     = 13;
    localparam int          SC_PS_LO     = 12;
    localparam int          SC_SCR_BYP   = 11;
    localparam int          SC_FIFO_HI   = 9;
    localparam int          SC_FIFO_LO   = 8;
    localparam int          SC_COL_FD    = 4;
    localparam int          SC_INT_POL   = 3;
    localparam int          SC_TEST_INT  = 2;
    localparam int          SC_INT_EN    = 1;
    localparam int          SC_INT_OE    = 0;
    localparam logic [15:0] SC_WMASK     = 16'hff1f;
    // power save selection codes
    localparam logic [1:0]  PS_NORMAL       = 2'h0;
    localparam logic [1:0]  PS_ACTIVE_SLEEP = 2'h2;
    // loopback fifo depths in nibbles for codes 0..3
    localparam logic [3:0]  FIFO_D0 = 4'h4;
    localparam logic [3:0]  FIFO_D1 = 4'h5;
    localparam logic [3:0]  FIFO_D2 = 4'h6;
    localparam logic [3:0]  FIFO_D3 = 4'h8;
    // pending flags start eight bits above their enables
    localparam int          PEND_SHIFT = 8;
    localparam logic [7:0]  HALF_FULL  = 8'h7f;
    localparam logic [7:0]  CNT_MAX    = 8'hff;
    // timing
    localparam longint      CLK_HZ         = 50_000_000;
    localparam longint      NLP_PERIOD_MS  = 1400;
    localparam longint      NLP_CYCLES     = (CLK_HZ * NLP_PERIOD_MS) / 1000;
    // sleep state machine
    typedef enum logic [0:0] {PIPC_AWAKE, PIPC_SLEEP} pipc_sleep_t;
endpackage

// file: hw/pipc_event_counter.sv
// saturating 8-bit event counter with read clear and half-full event
`timescale 1ns/100ps
`default_nettype none
module pipc_event_counter (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // event and clear
    input  wire logic       event_in,
    input  wire logic       rd_clear,
    // state
    output logic [7:0]      count,
    output logic            half_full_evt
);
    import pipc_pkg::*;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    // saturate at max, a read clears but an event in the same cycle counts one
    assign cnt_d = rd_clear ? {7'h00, event_in}
                 : (event_in && cnt_q != CNT_MAX) ? cnt_q + 8'h01 : cnt_q;
    // pulse when the count first passes half full
    assign half_full_evt = (cnt_d > HALF_FULL) && !(cnt_q > HALF_FULL);
    assign count = cnt_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    // a read clear resets count unless an event lands that same cycle
    property p_cnt_clear;
        @(posedge hclk) disable iff (!hresetn)
        rd_clear && !event_in |=> cnt_q == 8'h00;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared by read");
endmodule
`default_nettype wire

// file: hw/pipc_top.sv
// top: phy special control, interrupt status/enable registers and interrupt pin over ahb-lite
// Functional notes
// - clock disable acts only while in standard power-down.
// - power save enable applies selection: 0 normal, 1 reserved, 2 active sleep.
// - active sleep powers down all but management and energy detect, pulses every 1.4 s.
// - scrambler bit set bypasses scrambler and descrambler.
// - far-end loopback passes nibbles through the elastic fifo of that depth.
// - collision output in half duplex, also full duplex when its bit is set.
// - polarity 1 (reset) idles high, active low; 0 idles low, active high.
// - test interrupt bit raises an interrupt for as long as it is set.
// - master enable gates event interrupts, each by its own enable.
// - output enable 0 makes the shared pin a power-down input, 1 an interrupt output.
// - link, speed, duplex changes set read-to-clear flags.
// - link quality change with link up, and energy change, set flags.
// - auto-negotiation complete sets a flag held until read.
// - false carrier counter above half full sets a flag.
// - receive error counter above half full sets a flag.
// - low eight bits are read/write enables reset 0, matching flags eight higher.
// - counter is half full once above 7fh, raising its event.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module pipc_top #(
    parameter longint NLP_CYCLES_P = pipc_pkg::NLP_CYCLES
) (
    // ahb-lite slave
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // phy status inputs
    input  wire logic        link_up,
    input  wire logic        speed_10,
    input  wire logic        full_duplex,
    input  wire logic        link_quality_good,
    input  wire logic        energy_detect,
    input  wire logic        an_complete,
    input  wire logic        false_carrier_evt,
    input  wire logic        rx_error_evt,
    input  wire logic        collision_raw,
    input  wire logic        ieee_power_down,
    input  wire logic        far_end_loopback,
    // loopback nibbles
    input  wire logic [3:0]  lb_rx_nibble,
    input  wire logic        lb_rx_valid,
    input  wire logic        lb_tx_take,
    output logic [3:0]       lb_tx_nibble,
    output logic             lb_tx_valid,
    // power and datapath controls
    output logic             clk_disable,
    output logic             sleep_power_down,
    output logic             nlp_pulse,
    output logic             scrambler_bypass,
    output logic [3:0]       lb_fifo_depth,
    output logic             collision_out,
    // shared interrupt or power-down pin
    input  wire logic        intr_pd_in,
    output logic             intr_pd_out,
    output logic             intr_pd_oe,
    output logic             pin_power_down
);
    import pipc_pkg::*;

    logic [15:0] sc_q;
    logic [7:0]  pend_q;
    logic [7:0]  ena_q;
    logic [7:0]  pend_d;
    logic [15:0] int_two_q;
    logic        ph_valid_q;
    logic        ph_write_q;
    logic [7:0]  ph_idx_q;
    logic        link_q;
    logic        speed_q;
    logic        dup_q;
    logic        qual_q;
    logic        energy_q;
    logic        an_q;
    logic [7:0]  fc_count;
    logic [7:0]  re_count;
    logic        fc_half;
    logic        re_half;
    logic [31:0] nlp_cnt_q;
    logic [31:0] hrdata_q;
    logic [3:0]  fifo_q [8];
    logic [2:0]  wr_ptr_q;
    logic [2:0]  rd_ptr_q;
    logic [3:0]  fill_q;
    pipc_sleep_t sleep_q;

    // address phase decode
    wire         take     = hsel && hready && htrans[1];
    wire [7:0]   take_idx = haddr[ADDR_LSB+7:ADDR_LSB];
    wire         wr_sc    = ph_valid_q && ph_write_q && ph_idx_q == IDX_SPECIAL_CONTROL;
    wire         wr_one   = ph_valid_q && ph_write_q && ph_idx_q == IDX_INT_ONE;
    wire         wr_two   = ph_valid_q && ph_write_q && ph_idx_q == IDX_INT_TWO;
    wire         rd_one   = take && !hwrite && take_idx == IDX_INT_ONE;
    wire         rd_fc    = take && !hwrite && take_idx == IDX_FALSE_CARRIER;
    wire         rd_re    = take && !hwrite && take_idx == IDX_RX_ERROR;

    // address phase register, zero wait state slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid_q <= 1'b0;
            ph_write_q <= 1'b0;
            ph_idx_q   <= 8'h00;
        end else begin
            ph_valid_q <= take;
            ph_write_q <= hwrite;
            ph_idx_q   <= take_idx;
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // control register write, reserved bits stay zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sc_q      <= RST_SPECIAL_CONTROL;
            ena_q     <= RST_INT_ONE[7:0];
            int_two_q <= RST_INT_TWO;
        end else begin
            if (wr_sc) sc_q <= hwdata[15:0] & SC_WMASK;
            if (wr_one) ena_q <= hwdata[7:0];
            if (wr_two) int_two_q <= {8'h00, hwdata[7:0]};
        end
    end

    // event counters for false carrier and receive error
    pipc_event_counter u_fc (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .event_in      (false_carrier_evt),
        .rd_clear      (rd_fc),
        .count         (fc_count),
        .half_full_evt (fc_half)
    );
    pipc_event_counter u_re (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .event_in      (rx_error_evt),
        .rd_clear      (rd_re),
        .count         (re_count),
        .half_full_evt (re_half)
    );

    // events in flag order: quality, energy, link, speed, duplex, an, fc, re
    wire [7:0] evt = {
        (link_quality_good != qual_q) && link_up,
        energy_detect != energy_q,
        link_up != link_q,
        speed_10 != speed_q,
        full_duplex != dup_q,
        an_complete && !an_q,
        fc_half,
        re_half
    };
    // read clears flags, a same-cycle event wins
    assign pend_d = (rd_one ? 8'h00 : pend_q) | evt;

    // status history and pending flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q   <= RST_INT_ONE[15:8];
            link_q   <= 1'b0;
            speed_q  <= 1'b0;
            dup_q    <= 1'b0;
            qual_q   <= 1'b0;
            energy_q <= 1'b0;
            an_q     <= 1'b0;
        end else begin
            pend_q   <= pend_d;
            link_q   <= link_up;
            speed_q  <= speed_10;
            dup_q    <= full_duplex;
            qual_q   <= link_quality_good;
            energy_q <= energy_detect;
            an_q     <= an_complete;
        end
    end

    // read data mux
    wire [15:0] rd_word =
        (take_idx == IDX_SPECIAL_CONTROL) ? sc_q :
        (take_idx == IDX_INT_ONE)         ? {pend_q, ena_q} :
        (take_idx == IDX_INT_TWO)         ? int_two_q :
        (take_idx == IDX_FALSE_CARRIER)   ? {8'h00, fc_count} :
        (take_idx == IDX_RX_ERROR)        ? {8'h00, re_count} :
        (take_idx == IDX_PHY_INPUTS)      ? {9'h000, sleep_q == PIPC_SLEEP, an_complete,
                                             energy_detect, link_quality_good, full_duplex,
                                             speed_10, link_up} : 16'h0000;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata_q <= {16'h0000, rd_word};
        end
    end
    assign hrdata = hrdata_q;

    // interrupt generation
    wire ps_sel_sleep = sc_q[SC_PS_EN] && sc_q[SC_PS_HI:SC_PS_LO] == PS_ACTIVE_SLEEP;
    wire event_int    = sc_q[SC_INT_EN] && |(pend_q & ena_q);
    wire int_active   = sc_q[SC_INT_OE] && (event_int || sc_q[SC_TEST_INT]);
    assign intr_pd_oe     = sc_q[SC_INT_OE];
    assign intr_pd_out    = int_active ? !sc_q[SC_INT_POL] : sc_q[SC_INT_POL];
    assign pin_power_down = !sc_q[SC_INT_OE] && !intr_pd_in;

    // controls into the phy
    assign clk_disable      = sc_q[SC_CLK_DIS] && ieee_power_down;
    assign scrambler_bypass = sc_q[SC_SCR_BYP];
    assign collision_out    = collision_raw && (!full_duplex || sc_q[SC_COL_FD]);
    assign lb_fifo_depth    = (sc_q[SC_FIFO_HI:SC_FIFO_LO] == 2'h0) ? FIFO_D0 :
                              (sc_q[SC_FIFO_HI:SC_FIFO_LO] == 2'h1) ? FIFO_D1 :
                              (sc_q[SC_FIFO_HI:SC_FIFO_LO] == 2'h2) ? FIFO_D2 : FIFO_D3;

    // active sleep: wake on energy, nlp every period
    wire nlp_wrap = nlp_cnt_q == 32'(NLP_CYCLES_P - 1);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_q   <= PIPC_AWAKE;
            nlp_cnt_q <= 32'h0000_0000;
        end else begin
            case (sleep_q)
                PIPC_AWAKE: begin
                    nlp_cnt_q <= 32'h0000_0000;
                    if (ps_sel_sleep && !energy_detect) sleep_q <= PIPC_SLEEP;
                end
                PIPC_SLEEP: begin
                    nlp_cnt_q <= nlp_wrap ? 32'h0000_0000 : nlp_cnt_q + 32'h0000_0001;
                    if (energy_detect || !ps_sel_sleep) sleep_q <= PIPC_AWAKE;
                end
                default: sleep_q <= PIPC_AWAKE;
            endcase
        end
    end
    assign sleep_power_down = sleep_q == PIPC_SLEEP;
    assign nlp_pulse        = sleep_q == PIPC_SLEEP && nlp_wrap;

    // far-end loopback elastic fifo, released once filled to the chosen depth
    wire lb_push = far_end_loopback && lb_rx_valid && fill_q < 4'h8;
    wire lb_pop  = lb_tx_valid && lb_tx_take;
    // next fill drives valid, so a pop never runs past empty
    wire [3:0] fill_d = fill_q + {3'h0, lb_push} - {3'h0, lb_pop};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_q    <= 3'h0;
            rd_ptr_q    <= 3'h0;
            fill_q      <= 4'h0;
            lb_tx_valid <= 1'b0;
        end else if (!far_end_loopback) begin
            wr_ptr_q    <= 3'h0;
            rd_ptr_q    <= 3'h0;
            fill_q      <= 4'h0;
            lb_tx_valid <= 1'b0;
        end else begin
            if (lb_push) wr_ptr_q <= wr_ptr_q + 3'h1;
            if (lb_pop) rd_ptr_q <= rd_ptr_q + 3'h1;
            fill_q <= fill_d;
            if (fill_d >= lb_fifo_depth) lb_tx_valid <= 1'b1;
            else if (fill_d == 4'h0) lb_tx_valid <= 1'b0;
        end
    end
    always_ff @(posedge hclk) begin
        if (lb_push) fifo_q[wr_ptr_q] <= lb_rx_nibble;
    end
    assign lb_tx_nibble = fifo_q[rd_ptr_q];

    // checks
    property p_rd_clear;
        @(posedge hclk) disable iff (!hresetn)
        rd_one && evt == 8'h00 |=> pend_q == 8'h00;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("flags survived read");
    property p_set_wins;
        @(posedge hclk) disable iff (!hresetn)
        rd_one && evt[2] |=> pend_q[2];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost at clear");
    property p_pol;
        @(posedge hclk) disable iff (!hresetn)
        !sc_q[SC_TEST_INT] && !sc_q[SC_INT_EN] |-> intr_pd_out == sc_q[SC_INT_POL];
    endproperty
    a_pol: assert property (p_pol) else $error("idle level wrong");
    property p_test;
        @(posedge hclk) disable iff (!hresetn)
        sc_q[SC_TEST_INT] && sc_q[SC_INT_OE] |-> intr_pd_out != sc_q[SC_INT_POL];
    endproperty
    a_test: assert property (p_test) else $error("test interrupt missing");
    property p_master;
        @(posedge hclk) disable iff (!hresetn)
        !sc_q[SC_INT_EN] && !sc_q[SC_TEST_INT] |-> !int_active;
    endproperty
    a_master: assert property (p_master) else $error("ungated interrupt");
    property p_event_int;
        @(posedge hclk) disable iff (!hresetn)
        $rose(pend_q[5]) && ena_q[5] && sc_q[SC_INT_EN] && sc_q[SC_INT_OE] |-> int_active;
    endproperty
    a_event_int: assert property (p_event_int) else $error("link interrupt missing");
    property p_pin;
        @(posedge hclk) disable iff (!hresetn)
        (intr_pd_oe == sc_q[SC_INT_OE]) && !(intr_pd_oe && pin_power_down);
    endproperty
    a_pin: assert property (p_pin) else $error("shared pin role wrong");
    property p_col;
        @(posedge hclk) disable iff (!hresetn)
        full_duplex && !sc_q[SC_COL_FD] |-> !collision_out;
    endproperty
    a_col: assert property (p_col) else $error("collision in full duplex");
    property p_wake;
        @(posedge hclk) disable iff (!hresetn)
        sleep_q == PIPC_SLEEP && energy_detect |=> sleep_q == PIPC_AWAKE;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on partner");
    c_sleep: cover property (@(posedge hclk) disable iff (!hresetn) sleep_q == PIPC_SLEEP);
    c_int: cover property (@(posedge hclk) disable iff (!hresetn) event_int && sc_q[SC_INT_OE]);
    c_lb: cover property (@(posedge hclk) disable iff (!hresetn) lb_pop);
endmodule
`default_nettype wire

// file: bench/pipc_pin_env.sv
// far side of the shared interrupt or power-down pin: board pull-up and an external power-down driver
`timescale 1ns/100ps
`default_nettype none
module pipc_pin_env (
    // device side of the pin
    input  wire logic drv_en,
    input  wire logic drv_val,
    // board side
    input  wire logic ext_pd,
    output logic      pin
);
    // device drives when enabled, else the board pulls low for power-down or pulls up
    assign pin = drv_en ? drv_val : (ext_pd ? 1'b0 : 1'b1);
endmodule
`default_nettype wire

// file: bench/tb_pipc_top.sv
// self-checking testbench for the phy interrupt and power control block
`timescale 1ns/100ps
`default_nettype none
module tb_pipc_top;
    import pipc_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        link_up, speed_10, full_duplex, lq_good, energy, an_done, fc_evt, re_evt, col_raw, ieee_pd;
    logic [3:0]  lb_tx_nibble, lb_fifo_depth;
    logic        lb_tx_valid, clk_disable, sleep_pd, nlp_pulse, scr_byp, col_out;
    logic        pin, ext_pd, intr_pd_out, intr_pd_oe, pin_power_down;
    logic [15:0] v;
    logic        fel, lb_rx_vld, lb_take;
    logic [3:0]  lb_rx_nib;
    logic [3:0]  nib [5];
    int          i;
    localparam int NLP_SIM = 50;   // short sleep pulse period for simulation
    int          err_total, check_count, n;

    assign hready = hreadyout;

    pipc_top #(.NLP_CYCLES_P(NLP_SIM)) u_pipc_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .link_up(link_up), .speed_10(speed_10), .full_duplex(full_duplex),
        .link_quality_good(lq_good), .energy_detect(energy), .an_complete(an_done),
        .false_carrier_evt(fc_evt), .rx_error_evt(re_evt), .collision_raw(col_raw),
        .ieee_power_down(ieee_pd), .far_end_loopback(fel), .lb_rx_nibble(lb_rx_nib), .lb_rx_valid(lb_rx_vld),
        .lb_tx_take(lb_take), .lb_tx_nibble(lb_tx_nibble), .lb_tx_valid(lb_tx_valid),
        .clk_disable(clk_disable), .sleep_power_down(sleep_pd), .nlp_pulse(nlp_pulse),
        .scrambler_bypass(scr_byp), .lb_fifo_depth(lb_fifo_depth), .collision_out(col_out),
        .intr_pd_in(pin), .intr_pd_out(intr_pd_out), .intr_pd_oe(intr_pd_oe),
        .pin_power_down(pin_power_down));

    pipc_pin_env u_pipc_pin_env (.drv_en(intr_pd_oe), .drv_val(intr_pd_out), .ext_pd(ext_pd), .pin(pin));

    // clock source
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // expected loopback depth for a code
    function automatic logic [3:0] fdepth(input logic [1:0] c);
        case (c)
            2'h0: fdepth = FIFO_D0;
            2'h1: fdepth = FIFO_D1;
            2'h2: fdepth = FIFO_D2;
            default: fdepth = FIFO_D3;
        endcase
    endfunction

    task automatic close_out();
        if (err_total == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // wait for hready sampled high at a rising edge
    task automatic wait_rdy();
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            err_total++;
            close_out();
        end
    endtask

    // one single-word transfer at register index idx
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        chk(hresp, 1'b0);
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge hclk);
        #1;
    endtask

    // hang guard
    initial begin
        repeat (100000) @(posedge hclk);
        err_total++;
        close_out();
    end

    initial begin
        {hresetn, hsel, hwrite, link_up, speed_10, full_duplex, lq_good, energy} = '0;
        {an_done, fc_evt, re_evt, col_raw, ieee_pd, ext_pd} = '0;
        {fel, lb_rx_vld, lb_take, lb_rx_nib} = '0;
        haddr = '0; hwdata = '0; htrans = '0; hsize = 3'h2;
        err_total = 0; check_count = 0;
        void'($urandom(21157));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk(intr_pd_oe, 1'b0);
        chk(lb_fifo_depth, 4'h5);
        bus(0, IDX_SPECIAL_CONTROL, 0); chk(rd, 32'h0108);
        bus(0, IDX_INT_ONE, 0); chk(rd, 32'h0);
        bus(1, 8'h1f, 32'hffff); bus(0, 8'h1f, 0); chk(rd, 32'h0);
        // events pend while the master enable is off
        bus(1, IDX_INT_ONE, 32'h00ff);
        bus(1, IDX_SPECIAL_CONTROL, 32'h0109);
        @(posedge hclk); link_up <= 1'b1;
        tick(3);
        @(posedge hclk); lq_good <= 1'b1; energy <= 1'b1;
        tick(3);
        chk(intr_pd_out, 1'b1);
        bus(1, IDX_SPECIAL_CONTROL, 32'h010b); tick(2);
        chk(intr_pd_out, 1'b0);
        bus(0, IDX_INT_ONE, 0); chk(rd, 32'he0ff);
        tick(2);
        chk(intr_pd_out, 1'b1);
        // forced interrupt with both polarities, idle low level, then the pin as power-down input
        bus(1, IDX_SPECIAL_CONTROL, 32'h010d); tick(2);
        chk(intr_pd_out, 1'b0);
        bus(1, IDX_SPECIAL_CONTROL, 32'h0105); tick(2);
        chk(intr_pd_out, 1'b1);
        bus(1, IDX_SPECIAL_CONTROL, 32'h0101); tick(2);
        chk(intr_pd_out, 1'b0);
        bus(1, IDX_SPECIAL_CONTROL, 32'h0104);
        @(posedge hclk); ext_pd <= 1'b1;
        tick(2);
        chk({intr_pd_oe, pin_power_down}, 2'b01);
        @(posedge hclk); ext_pd <= 1'b0;
        // counters past half full
        bus(0, IDX_INT_ONE, 0);
        repeat (128) begin
            @(posedge hclk); fc_evt <= 1'b1; re_evt <= 1'b1;
            @(posedge hclk); fc_evt <= 1'b0; re_evt <= 1'b0;
        end
        tick(3);
        bus(0, IDX_INT_ONE, 0); chk(rd, 32'h03ff);
        bus(0, IDX_FALSE_CARRIER, 0); chk(rd, 32'h0080);
        bus(0, IDX_RX_ERROR, 0); chk(rd, 32'h0080);
        bus(0, IDX_FALSE_CARRIER, 0); chk(rd, 32'h0);
        // auto-negotiation flag holds until read
        @(posedge hclk); an_done <= 1'b1;
        tick(10);
        bus(0, IDX_INT_ONE, 0); chk(rd, 32'h04ff);
        bus(0, IDX_INT_ONE, 0); chk(rd, 32'h00ff);
        // reserved selection keeps full power, active sleep pulses each period and wakes on energy
        @(posedge hclk); energy <= 1'b0;
        bus(1, IDX_SPECIAL_CONTROL, 32'h5108); tick(5);
        chk(sleep_pd, 1'b0);
        bus(1, IDX_SPECIAL_CONTROL, 32'h6108);
        n = 0;
        while (nlp_pulse !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk(n, NLP_SIM);
        if (n >= 200) close_out();
        chk(sleep_pd, 1'b1);
        tick(NLP_SIM);
        chk(nlp_pulse, 1'b1);
        @(posedge hclk); energy <= 1'b1;
        tick(5);
        chk(sleep_pd, 1'b0);
        // far-end loopback holds nibbles until five are in, then hands them on in order
        @(posedge hclk); fel <= 1'b1;
        for (i = 0; i < 5; i++) begin
            @(posedge hclk);
            nib[i] = 4'($urandom());
            lb_rx_nib <= nib[i]; lb_rx_vld <= 1'b1;
        end
        #1;
        chk(lb_tx_valid, 1'b0);
        @(posedge hclk); lb_rx_vld <= 1'b0; lb_take <= 1'b1;
        #1;
        chk(lb_tx_valid, 1'b1);
        for (i = 0; i < 5; i++) begin
            chk(lb_tx_nibble, nib[i]);
            tick(1);
        end
        chk(lb_tx_valid, 1'b0);
        @(posedge hclk); lb_take <= 1'b0; fel <= 1'b0;
        // random control words, datapath controls and pin follow the fields
        repeat (40) begin
            v = 16'($urandom());
            @(posedge hclk);
            col_raw <= 1'($urandom());
            full_duplex <= 1'($urandom());
            ieee_pd <= 1'($urandom());
            bus(1, IDX_SPECIAL_CONTROL, {16'h0, v});
            bus(0, IDX_SPECIAL_CONTROL, 0);
            chk(rd, {16'h0, v & SC_WMASK});
            tick(1);
            chk(scr_byp, v[SC_SCR_BYP]);
            chk(lb_fifo_depth, fdepth(v[9:8]));
            chk(col_out, col_raw & (~full_duplex | v[SC_COL_FD]));
            chk(clk_disable, v[SC_CLK_DIS] & ieee_pd);
            chk(intr_pd_oe, v[SC_INT_OE]);
            if (v[SC_TEST_INT]) chk(intr_pd_out, v[SC_INT_POL] ^ v[SC_INT_OE]);
        end
        close_out();
    end
endmodule
`default_nettype wire
